// >>> hbd_spi_diag.sv
// Purpose: SPI slave with protection and diagnosis of ten half-bridges
// Assumes: i_sclk idles low around chip select edges; pins are asynchronous
// Notes:   Frame words cross domains quasi-statically while select is high

// --------------------------------------------------------------
// Two-stage synchroniser
// --------------------------------------------------------------
module hbd_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clock,
    input  wire logic         i_rstn,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } hbd_sync_t;

    hbd_sync_t sync_ff;
    hbd_sync_t nxt_sync;

    always_comb begin
        nxt_sync.meta   = i_async;
        nxt_sync.stable = sync_ff.meta;
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            sync_ff <= '0;
        end else begin
            sync_ff <= nxt_sync;
        end
    end

    assign o_sync = sync_ff.stable;
endmodule

// --------------------------------------------------------------
// Top
// --------------------------------------------------------------
module hbd_spi_diag #(
    parameter int unsigned OC_DELAY_CYC = hbd_pkg::OC_DELAY_CYC,
    parameter int unsigned OL_DELAY_CYC = hbd_pkg::OL_DELAY_CYC,
    parameter int unsigned DEAD_CYC     = hbd_pkg::DEAD_CYC
) (
    input  wire logic       i_clock,
    input  wire logic       i_rstn,
    input  wire logic       i_sclk,
    input  wire logic       i_chip_select_n,
    input  wire logic       i_serial_in_line,
    output logic            o_serial_out_line,
    output logic            o_serial_out_line_oe,
    input  wire logic       i_sleep_control_pin,
    input  wire logic       i_logic_supply_low,
    input  wire logic       i_load_undervoltage,
    input  wire logic       i_load_overvoltage,
    input  wire logic       i_temp_warning,
    input  wire logic       i_temp_shutdown,
    input  wire logic [9:0] i_hs_over_current,
    input  wire logic [9:0] i_ls_over_current,
    input  wire logic [9:0] i_ls_under_current,
    input  wire logic [9:0] i_cross_current,
    output logic      [9:0] o_hs_on,
    output logic      [9:0] o_ls_on,
    output logic            o_supply_fail_flag,
    output logic            o_thermal_warning_flag,
    output logic            o_thermal_shutdown,
    output logic      [9:0] o_hs_overcurrent_flag,
    output logic      [9:0] o_ls_overcurrent_flag,
    output logic      [9:0] o_open_load_flag
);
    if (OC_DELAY_CYC < 1 || OC_DELAY_CYC >= 65535) begin : g_bad_oc
        $error("OC_DELAY_CYC out of range");
    end
    if (OL_DELAY_CYC < 1 || OL_DELAY_CYC >= 16777215) begin : g_bad_ol
        $error("OL_DELAY_CYC out of range");
    end
    if (DEAD_CYC < 1 || DEAD_CYC > 255) begin : g_bad_dead
        $error("DEAD_CYC out of range");
    end

    localparam logic [15:0] OC_LIM = 16'(OC_DELAY_CYC);
    localparam logic [23:0] OL_LIM = 24'(OL_DELAY_CYC);
    localparam logic [7:0]  DT_LIM = 8'(DEAD_CYC);

    typedef struct packed {
        logic             csn_d;
        logic             tog;
        logic [9:0]       act;
        logic [9:0]       conf;
        logic [1:0]       olsd;
        logic             sel_addr;
        logic             clr_pend;
        logic             clr_addr;
        logic [15:0]      tx;
        logic             sdo_oe;
        logic             supply_fail_flag;
        logic             tw;
        logic             tsd;
        logic [9:0]       oc_hs;
        logic [9:0]       oc_ls;
        logic [9:0]       ol;
        logic [9:0]       ol_lock;
        logic [9:0][15:0] hs_cnt;
        logic [9:0][15:0] ls_cnt;
        logic [9:0][23:0] ol_cnt;
        logic [9:0][1:0]  tgt;
        logic [9:0][7:0]  dt;
        logic [9:0]       hs_on;
        logic [9:0]       ls_on;
    } hbd_sys_t;

    typedef struct packed {
        logic [15:0] sr;
        logic [2:0]  bits;
        logic [1:0]  bytes;
        logic        seen;
    } hbd_link_t;

    // --------------------------------------------------------------
    // Pin synchronisation
    // --------------------------------------------------------------
    logic [46:0] sync_v;
    logic        csn_s;
    logic        inh_s;
    logic        vddl_s;
    logic        uv_s;
    logic        ov_s;
    logic        tw_s;
    logic        tsd_s;
    logic [9:0]  hsoc_s;
    logic [9:0]  lsoc_s;
    logic [9:0]  lsuc_s;
    logic [9:0]  xc_s;

    hbd_sync #(
        .W (47)
    ) u_sync (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_async ({i_chip_select_n, i_sleep_control_pin, i_logic_supply_low,
                   i_load_undervoltage, i_load_overvoltage, i_temp_warning,
                   i_temp_shutdown, i_hs_over_current, i_ls_over_current,
                   i_ls_under_current, i_cross_current}),
        .o_sync  (sync_v)
    );

    assign {csn_s, inh_s, vddl_s, uv_s, ov_s, tw_s, tsd_s,
            hsoc_s, lsoc_s, lsuc_s, xc_s} = sync_v;

    hbd_sys_t  sys_ff;
    hbd_sys_t  nxt_sys;
    hbd_link_t lnk_ff;
    hbd_link_t nxt_lnk;

    localparam hbd_sys_t SYS_RST = '0;

    function automatic logic [15:0] hbd_status(input logic g, input hbd_sys_t v);
        logic [15:0] w;
        w = '0;
        w[hbd_pkg::ST_PSF]  = v.supply_fail_flag;
        w[hbd_pkg::ST_TW]   = v.tw;
        w[hbd_pkg::ST_TSD]  = v.tsd;
        w[hbd_pkg::ST_ADDR] = g;
        if (!g) begin
            w[hbd_pkg::ST_OL_LSB +: 6] = v.ol[5:0];
            w[hbd_pkg::ST_OC_LSB +: 6] = v.oc_hs[5:0] | v.oc_ls[5:0];
        end else begin
            w[hbd_pkg::ST_OL_LSB +: 4] = v.ol[9:6];
            w[hbd_pkg::ST_OC_LSB +: 4] = v.oc_hs[9:6] | v.oc_ls[9:6];
        end
        return w;
    endfunction

    // --------------------------------------------------------------
    // Serial clock domain
    // --------------------------------------------------------------
    logic first_bit;

    always_comb begin
        nxt_lnk = lnk_ff;
        // select rise makes the system toggle differ from the last seen one
        first_bit = (sys_ff.tog != lnk_ff.seen);
        // sample at falling edge, shift MSB first
        if (first_bit) begin
            nxt_lnk.sr    = {sys_ff.tx[14:0], i_serial_in_line};
            nxt_lnk.bits  = 3'h1;
            nxt_lnk.bytes = 2'h0;
        end else begin
            nxt_lnk.sr    = {lnk_ff.sr[14:0], i_serial_in_line};
            nxt_lnk.bits  = lnk_ff.bits + 3'h1;
            if (lnk_ff.bits == 3'h7 && lnk_ff.bytes != 2'h2) begin
                nxt_lnk.bytes = lnk_ff.bytes + 2'h1;
            end
        end
        nxt_lnk.seen = sys_ff.tog;
    end

    always_ff @(negedge i_sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            lnk_ff <= '{sr: 16'h0000, bits: 3'h0, bytes: 2'h0, seen: 1'b1};
        end else begin
            lnk_ff <= nxt_lnk;
        end
    end

    // --------------------------------------------------------------
    // System clock domain
    // --------------------------------------------------------------
    logic       csn_rise;
    logic       frame_ok;
    logic       soft_rst;
    logic       clr0;
    logic       clr1;
    logic       any_clr;
    logic [9:0] clr_m;
    logic       allow;
    logic [1:0] tgt;
    logic       grp_olsd;
    logic       trip_h;
    logic       trip_l;
    logic       trip_o;

    always_comb begin
        nxt_sys  = sys_ff;
        tgt      = 2'h0;
        grp_olsd = 1'b0;
        trip_h   = 1'b0;
        trip_l   = 1'b0;
        trip_o   = 1'b0;
        // sleep pin low or logic supply low acts as a reset
        soft_rst = ~inh_s | vddl_s;
        csn_rise = csn_s & ~sys_ff.csn_d;
        // accept only frames with clock edges and whole bytes, at least a word
        frame_ok = csn_rise & (lnk_ff.seen == sys_ff.tog)
                 & (lnk_ff.bits == 3'h0) & (lnk_ff.bytes == 2'h2);
        nxt_sys.csn_d = csn_s;
        if (csn_rise) begin
            nxt_sys.tog = ~sys_ff.tog;
        end
        // release the serial output once select is high
        nxt_sys.sdo_oe = ~csn_s & ~soft_rst;

        // supply fail follows both comparators, unlatched
        nxt_sys.supply_fail_flag = uv_s | ov_s;
        nxt_sys.tw  = tw_s;

        // clear pending from the previous frame, on the address that frame carried
        clr0    = frame_ok & sys_ff.clr_pend & ~sys_ff.clr_addr;
        clr1    = frame_ok & sys_ff.clr_pend & sys_ff.clr_addr;
        any_clr = clr0 | clr1;
        clr_m   = {{hbd_pkg::N_HB1{clr1}}, {hbd_pkg::N_HB0{clr0}}};

        // shutdown latched; a new event wins over the clear
        nxt_sys.tsd = tsd_s | (sys_ff.tsd & ~any_clr);
        allow = ~nxt_sys.supply_fail_flag & ~nxt_sys.tsd;

        for (int i = 0; i < hbd_pkg::N_HB; i++) begin
            grp_olsd = (i < hbd_pkg::N_HB0) ? sys_ff.olsd[0] : sys_ff.olsd[1];
            // qualify overcurrent for longer than the delay
            nxt_sys.hs_cnt[i] = '0;
            nxt_sys.ls_cnt[i] = '0;
            if (sys_ff.hs_on[i] & hsoc_s[i]) begin
                nxt_sys.hs_cnt[i] = (sys_ff.hs_cnt[i] == OC_LIM) ? OC_LIM
                                  : sys_ff.hs_cnt[i] + 16'h0001;
            end
            if (sys_ff.ls_on[i] & lsoc_s[i]) begin
                nxt_sys.ls_cnt[i] = (sys_ff.ls_cnt[i] == OC_LIM) ? OC_LIM
                                  : sys_ff.ls_cnt[i] + 16'h0001;
            end
            trip_h = (sys_ff.hs_cnt[i] == OC_LIM);
            trip_l = (sys_ff.ls_cnt[i] == OC_LIM);
            // cross current latches both switches off
            nxt_sys.oc_hs[i] = trip_h | xc_s[i] | (sys_ff.oc_hs[i] & ~clr_m[i]);
            nxt_sys.oc_ls[i] = trip_l | xc_s[i] | (sys_ff.oc_ls[i] & ~clr_m[i]);
            nxt_sys.ol_cnt[i] = '0;
            if (sys_ff.ls_on[i] & lsuc_s[i]) begin
                nxt_sys.ol_cnt[i] = (sys_ff.ol_cnt[i] == OL_LIM) ? OL_LIM
                                  : sys_ff.ol_cnt[i] + 24'h000001;
            end
            trip_o = (sys_ff.ol_cnt[i] == OL_LIM);
            nxt_sys.ol[i] = trip_o | (sys_ff.ol[i] & ~clr_m[i]);
            // lock the output only if the group enable is set
            nxt_sys.ol_lock[i] = (trip_o & grp_olsd) | (sys_ff.ol_lock[i] & ~clr_m[i]);
            // activation and direction pick the wanted switch
            tgt = {allow & sys_ff.act[i] & sys_ff.conf[i] & ~nxt_sys.oc_hs[i],
                   allow & sys_ff.act[i] & ~sys_ff.conf[i] & ~nxt_sys.oc_ls[i]
                   & ~nxt_sys.ol_lock[i]};
            // any switch-on waits out the dead time; switch-off is immediate
            if (tgt != sys_ff.tgt[i] && tgt != 2'h0) begin
                nxt_sys.dt[i] = DT_LIM;
            end else if (sys_ff.dt[i] != 8'h00) begin
                nxt_sys.dt[i] = sys_ff.dt[i] - 8'h01;
            end
            nxt_sys.tgt[i]   = tgt;
            nxt_sys.hs_on[i] = tgt[1] & (nxt_sys.dt[i] == 8'h00);
            nxt_sys.ls_on[i] = tgt[0] & (nxt_sys.dt[i] == 8'h00);
        end

        // new control word at select rise
        if (frame_ok) begin
            nxt_sys.sel_addr = lnk_ff.sr[hbd_pkg::BIT_ADDR];
            nxt_sys.clr_addr = lnk_ff.sr[hbd_pkg::BIT_ADDR];
            nxt_sys.clr_pend = lnk_ff.sr[hbd_pkg::BIT_SRR];
            if (!lnk_ff.sr[hbd_pkg::BIT_ADDR]) begin
                nxt_sys.act[5:0]  = lnk_ff.sr[hbd_pkg::ACT_LSB +: 6];
                nxt_sys.conf[5:0] = lnk_ff.sr[hbd_pkg::CONF_LSB +: 6];
                nxt_sys.olsd[0]   = lnk_ff.sr[hbd_pkg::BIT_OLSD];
            end else begin
                nxt_sys.act[9:6]  = lnk_ff.sr[hbd_pkg::ACT_LSB +: 4];
                nxt_sys.conf[9:6] = lnk_ff.sr[hbd_pkg::CONF_LSB +: 4];
                nxt_sys.olsd[1]   = lnk_ff.sr[hbd_pkg::BIT_OLSD];
            end
        end

        // refresh the outgoing word only while select is steadily high
        if (csn_s & sys_ff.csn_d) begin
            nxt_sys.tx = hbd_status(sys_ff.sel_addr, sys_ff);
        end

        // reset banks but keep frame tracking aligned with the link side
        if (soft_rst) begin
            nxt_sys       = SYS_RST;
            nxt_sys.csn_d = csn_s;
            nxt_sys.tog   = sys_ff.tog;
        end
    end

    // power-on reset clears all, address 0, outputs off
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            sys_ff <= SYS_RST;
        end else begin
            sys_ff <= nxt_sys;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    // after the first bit the output is the shift register top, 16 bits late
    assign o_serial_out_line      = first_bit ? sys_ff.tx[15] : lnk_ff.sr[15];
    assign o_serial_out_line_oe   = sys_ff.sdo_oe;
    assign o_hs_on                = sys_ff.hs_on;
    assign o_ls_on                = sys_ff.ls_on;
    assign o_supply_fail_flag     = sys_ff.supply_fail_flag;
    assign o_thermal_warning_flag = sys_ff.tw;
    assign o_thermal_shutdown     = sys_ff.tsd;
    assign o_hs_overcurrent_flag  = sys_ff.oc_hs;
    assign o_ls_overcurrent_flag  = sys_ff.oc_ls;
    assign o_open_load_flag       = sys_ff.ol;

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);

    a_no_shoot_through: assert property ((sys_ff.hs_on & sys_ff.ls_on) == 10'h000)
        else $error("high and low switch on together");
    a_dead_gap: assert property ($fell(sys_ff.hs_on[0]) |-> !sys_ff.ls_on[0])
        else $error("low switch on without dead time");
    a_supply_off: assert property (sys_ff.supply_fail_flag |-> (sys_ff.hs_on | sys_ff.ls_on) == 10'h000)
        else $error("outputs on during supply fail");
    a_supply_flag: assert property (sys_ff.supply_fail_flag == $past(uv_s | ov_s))
        else $error("supply fail flag mismatch");
    a_warn_follow: assert property (!soft_rst |=> sys_ff.tw == $past(tw_s))
        else $error("thermal warning does not follow sensor");
    a_tsd_latched: assert property (sys_ff.tsd && !any_clr && !soft_rst |=> sys_ff.tsd)
        else $error("thermal shutdown lost without clear");
    a_tsd_off: assert property (sys_ff.tsd |-> (sys_ff.hs_on | sys_ff.ls_on) == 10'h000)
        else $error("outputs on during thermal shutdown");
    a_oc_trip: assert property (sys_ff.hs_cnt[0] == OC_LIM && !soft_rst
                                |=> sys_ff.oc_hs[0] && !sys_ff.hs_on[0])
        else $error("overcurrent not tripped after delay");
    a_oc_lock: assert property ((sys_ff.hs_on & sys_ff.oc_hs) == 10'h000)
        else $error("switch on with overcurrent latched");
    a_ol_trip: assert property (sys_ff.ol_cnt[1] == OL_LIM && !soft_rst |=> sys_ff.ol[1])
        else $error("open load not flagged after delay");
    a_ol_lock: assert property ((sys_ff.ls_on & sys_ff.ol_lock) == 10'h000)
        else $error("low switch on with open-load lock");
    a_cross_off: assert property (xc_s[1] && !soft_rst
                                  |=> sys_ff.oc_hs[1] && sys_ff.oc_ls[1]
                                      && !sys_ff.hs_on[1] && !sys_ff.ls_on[1])
        else $error("cross current did not latch both off");
    a_sleep_reset: assert property (soft_rst |=> sys_ff.act == hbd_pkg::RST_ACT
                                    && !sys_ff.sdo_oe && sys_ff.hs_on == 10'h000)
        else $error("sleep did not reset banks");
    a_bad_frame: assert property (csn_rise && !frame_ok && !soft_rst
                                  |=> $stable(sys_ff.act) && $stable(sys_ff.sel_addr))
        else $error("partial frame was accepted");
    a_word_taken: assert property (frame_ok && !soft_rst
                                   |=> sys_ff.sel_addr == $past(lnk_ff.sr[14]))
        else $error("control word not taken at select rise");
    a_sdo_release: assert property (csn_s |=> !sys_ff.sdo_oe)
        else $error("serial output driven with select high");

    c_frame_ok:  cover property (frame_ok);
    c_clear:     cover property (any_clr && sys_ff.oc_hs != 10'h000);
    c_oc_trip:   cover property ($rose(sys_ff.oc_ls[1]));
    c_switch_on: cover property ($rose(sys_ff.hs_on[0]));
endmodule

// >>> hbd_pkg.sv
// Purpose: Constants for the half-bridge SPI diagnosis block
// Assumes: 125 MHz system clock, 16-bit SPI frames
// Notes:   Status word layout and fault delays are local choices
package hbd_pkg;
    localparam int WORD_W    = 16;
    localparam int N_HB      = 10;
    localparam int N_HB0     = 6;
    localparam int N_HB1     = 4;
    // Control word fields
    localparam int BIT_SRR   = 15;
    localparam int BIT_ADDR  = 14;
    localparam int BIT_OLSD  = 13;
    localparam int ACT_LSB   = 7;
    localparam int CONF_LSB  = 1;
    // Status word fields
    localparam int ST_PSF    = 15;
    localparam int ST_TW     = 14;
    localparam int ST_TSD    = 13;
    localparam int ST_ADDR   = 12;
    localparam int ST_OL_LSB = 6;
    localparam int ST_OC_LSB = 0;
    // Reset values
    localparam logic       RST_ADDR = 1'b0;
    localparam logic [9:0] RST_ACT  = 10'h000;
    // Timing
    localparam int CLK_MHZ      = 125;
    localparam int DEAD_TIME_NS = 1000;
    localparam int OC_DELAY_NS  = 10000;
    localparam int OL_DELAY_NS  = 1000000;
    localparam int DEAD_CYC     = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int OC_DELAY_CYC = (OC_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int OL_DELAY_CYC = (OL_DELAY_NS * CLK_MHZ + 999) / 1000;
endpackage

// >>> hbd_spi_master.sv
// Purpose: SPI master model for the half-bridge diagnosis block
// Assumes: data valid at the falling serial clock edge
// Notes:   Clock stands low between frames; released data line is inverted
// ------------------------------------------------------------
// Master
// ------------------------------------------------------------
module hbd_spi_master (
    output logic      o_sclk,
    output logic      o_csn,
    output logic      o_sdi,
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_sclk = 1'h0;
        o_csn = 1'h1;
        o_sdi = 1'h0;
    end
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        o_csn = 1'h0;
        #120;
        for (int k = nbits - 1; k >= 0; k--) begin
            // Data moves away from the falling edge the block samples on
            #2 o_sdi = tx[k];
            #5.5 o_sclk = 1'h1;
            rx = {rx[14:0], i_sdo_oe ? i_sdo : 1'hx};
            #7.5 o_sclk = 1'h0;
        end
        #62 o_csn = 1'h1;
        o_sdi = ~o_sdi;
        #600;
    endtask
endmodule

// >>> hbd_spi_diag_tb_top.sv
// Purpose: Self-checking bench for the half-bridge SPI diagnosis block
// Assumes: fault delays shortened through parameters
// Notes:   Pins other than the SPI lines change at the falling system clock edge
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module hbd_spi_diag_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clock = 1'h0;
    logic        i_rstn = 1'h0;
    logic        sclk, chip_select_n, serial_in_line, serial_out_line, sdo_oe, supply_fail_flag, twf, tsdf;
    logic        sleep = 1'h1, vdd_low = 1'h0, uv = 1'h0, ov = 1'h0, tw = 1'h0, tsd = 1'h0;
    logic [9:0]  hs_oc = 10'h000, ls_oc = 10'h000, ls_uc = 10'h000, xc = 10'h000;
    logic [9:0]  hs_on, ls_on, hs_f, ls_f, ol_f;
    logic [15:0] rx;
    int          errors = 0, checked = 0, cycles = 0;

    hbd_spi_master mst_u (.o_sclk(sclk), .o_csn(chip_select_n), .o_sdi(serial_in_line), .i_sdo(serial_out_line), .i_sdo_oe(sdo_oe));
    hbd_spi_diag #(.OC_DELAY_CYC(8), .OL_DELAY_CYC(16), .DEAD_CYC(3)) dut_u (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_sclk(sclk), .i_chip_select_n(chip_select_n),
        .i_serial_in_line(serial_in_line), .o_serial_out_line(serial_out_line), .o_serial_out_line_oe(sdo_oe),
        .i_sleep_control_pin(sleep), .i_logic_supply_low(vdd_low),
        .i_load_undervoltage(uv), .i_load_overvoltage(ov), .i_temp_warning(tw),
        .i_temp_shutdown(tsd), .i_hs_over_current(hs_oc), .i_ls_over_current(ls_oc),
        .i_ls_under_current(ls_uc), .i_cross_current(xc), .o_hs_on(hs_on), .o_ls_on(ls_on),
        .o_supply_fail_flag(supply_fail_flag), .o_thermal_warning_flag(twf), .o_thermal_shutdown(tsdf),
        .o_hs_overcurrent_flag(hs_f), .o_ls_overcurrent_flag(ls_f), .o_open_load_flag(ol_f));

    initial forever #4 i_clock = ~i_clock;
    // Run is about 2210 cycles; limit leaves ample margin
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wcyc(input int n);
        repeat (n) @(posedge i_clock);
        @(negedge i_clock);
    endtask
    task automatic frame(input logic [15:0] w, input logic [15:0] exp_rx);
        @(negedge i_clock) mst_u.xfer(w, 16, rx);
        chk({16'h0000, rx}, {16'h0000, exp_rx});
        chk({31'h0, sdo_oe}, 32'h0);
    endtask
    task automatic s_ctrl();
        frame(16'h0182, 16'h0000);
        chk({12'h000, ls_on, hs_on}, {12'h000, 10'h002, 10'h001});
        frame(16'h4080, 16'h0000);
        frame(16'h0182, 16'h1000);
        chk({12'h000, ls_on, hs_on}, {12'h000, 10'h042, 10'h001});
        @(negedge i_clock) mst_u.xfer(16'h0000, 12, rx);
        chk({12'h000, ls_on, hs_on}, {12'h000, 10'h042, 10'h001});
    endtask
    task automatic s_supply();
        for (int i = 0; i < 2; i++) begin
            @(negedge i_clock) {ov, uv} = (i == 0) ? 2'h1 : 2'h2;
            wcyc(6);
            chk({11'h000, supply_fail_flag, ls_on, hs_on}, {11'h000, 1'h1, 20'h00000});
            frame(16'h0182, 16'h8000);
            @(negedge i_clock) {ov, uv} = 2'h0;
            wcyc(12);
            chk({11'h000, supply_fail_flag, ls_on, hs_on}, {12'h000, 10'h042, 10'h001});
        end
    endtask
    task automatic s_thermal();
        @(negedge i_clock) tw = 1'h1;
        wcyc(5);
        chk({31'h0, twf}, 32'h1);
        frame(16'h0182, 16'h4000);
        @(negedge i_clock) tw = 1'h0;
        wcyc(5);
        chk({31'h0, twf}, 32'h0);
        @(negedge i_clock) tsd = 1'h1;
        wcyc(2);
        @(negedge i_clock) tsd = 1'h0;
        wcyc(6);
        chk({11'h000, tsdf, ls_on, hs_on}, {11'h000, 1'h1, 20'h00000});
        frame(16'h8182, 16'h2000);
        chk({31'h0, tsdf}, 32'h1);
        frame(16'h0182, 16'h2000);
        chk({11'h000, tsdf, ls_on, hs_on}, {12'h000, 10'h042, 10'h001});
    endtask
    task automatic s_fault();
        @(negedge i_clock) hs_oc = 10'h001;
        wcyc(20);
        @(negedge i_clock) hs_oc = 10'h000;
        xc = 10'h002;
        wcyc(3);
        @(negedge i_clock) xc = 10'h000;
        wcyc(4);
        chk({12'h000, ls_on, hs_on}, {12'h000, 10'h040, 10'h000});
        chk({12'h000, ls_f, hs_f}, {12'h000, 10'h002, 10'h003});
        frame(16'h8182, 16'h0003);
        frame(16'h0182, 16'h0003);
        chk({12'h000, hs_f | ls_f, hs_on}, {12'h000, 10'h000, 10'h001});
    endtask
    task automatic s_openload();
        @(negedge i_clock) ls_uc = 10'h002;
        wcyc(30);
        chk({12'h000, ol_f, ls_on}, {12'h000, 10'h002, 10'h042});
        frame(16'h2182, 16'h0080);
        @(negedge i_clock) ls_uc = 10'h000;
        chk({12'h000, ol_f, ls_on}, {12'h000, 10'h002, 10'h040});
        frame(16'ha182, 16'h0080);
        frame(16'h0182, 16'h0080);
        chk({12'h000, ol_f, ls_on}, {12'h000, 10'h000, 10'h042});
    endtask
    task automatic s_sleep();
        for (int i = 0; i < 2; i++) begin
            @(negedge i_clock) {vdd_low, sleep} = (i == 0) ? 2'h0 : 2'h3;
            wcyc(6);
            chk({12'h000, ls_on, hs_on}, 32'h0);
            @(negedge i_clock) {vdd_low, sleep} = 2'h1;
            wcyc(12);
            chk({12'h000, ls_on, hs_on}, 32'h0);
            @(negedge i_clock) mst_u.xfer(16'h0182, 16, rx);
        end
    endtask

    initial begin
        repeat (2) @(posedge i_clock);
        @(negedge i_clock) i_rstn = 1'h1;
        wcyc(4);
        chk({8'h00, sdo_oe, supply_fail_flag, twf, tsdf, ls_on, hs_on}, 32'h0);
        chk({2'h0, ol_f, hs_f, ls_f}, 32'h0);
        s_ctrl();
        s_supply();
        s_thermal();
        s_fault();
        s_openload();
        s_sleep();
        conclude();
    end
endmodule
